/* src/egress_skid_buffer.sv */
// Two-entry egress staging buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module egress_skid_buffer
    import pkt_path_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         i_clock,
    input  wire logic         i_rst_b,
    input  wire logic [W-1:0] i_data,
    input  wire logic         i_valid,
    output logic              o_ready,
    output logic [W-1:0]      o_data,
    input  wire logic         i_ready,
    output logic              o_valid
);

    logic [1:0]   count;
    logic [1:0]   next_count;
    logic [W-1:0] slot0;
    logic [W-1:0] slot1;
    wire          push = i_valid && o_ready;
    wire          pop  = o_valid && i_ready;

    // Full only at two words, so the filling side stalls honestly
    assign o_ready    = (count != BUF_ENTRIES);
    assign o_valid    = (count != RST_COUNT);
    assign o_data     = slot0;
    assign next_count = 2'(count + {1'b0, push} - {1'b0, pop});

    // Head word always sits in slot0 so read data leave a register
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count <= RST_COUNT;
            slot0 <= '0;
            slot1 <= '0;
        end else begin
            count <= next_count;
            if (pop) begin
                slot0 <= (count == BUF_ENTRIES) ? slot1 : i_data;
            end else if (push && count == RST_COUNT) begin
                slot0 <= i_data;
            end
            if (push && count == 2'h1 && !pop) begin
                slot1 <= i_data;
            end
        end
    end

endmodule
`default_nettype wire

/* src/pkt_path_pkg.sv */
// Shared constants, descriptor and egress word types of the switch packet path
package pkt_path_pkg;

    // ==========================================================
    // Shared packet buffer size
    localparam int          BUF_MB        = 6;
    localparam int          BUF_BYTES     = BUF_MB * 1024 * 1024;
    localparam int          USED_W        = 23;
    localparam logic [22:0] BUF_BYTES_W   = 23'(BUF_BYTES);

    // ==========================================================
    // Geometry of ports and packets
    localparam int          PORTS         = 8;
    localparam int          LEN_W         = 14;

    // ==========================================================
    // Values after reset and egress buffer depth
    localparam logic [22:0] RST_USED      = 23'h000000;
    localparam logic [7:0]  RST_MASK      = 8'h00;
    localparam logic [1:0]  RST_COUNT     = 2'h0;
    localparam logic [1:0]  BUF_ENTRIES   = 2'h2;

    // Header fields handed to the ingress lookup; the body stays in the buffer
    typedef struct packed {
        logic [3:0]  dst_asic;
        logic [2:0]  dst_port;
        logic        mcast;
        logic [7:0]  oif;
        logic        remote_rcv;
        logic        wireless_dst;
        logic        from_ap;
        logic [13:0] len;
    } hdr_t;

    // Fixed descriptor shared by every scheduler and controller
    typedef struct packed {
        logic [3:0]  dst_asic;
        logic [2:0]  dst_port;
        logic        mcast;
        logic [7:0]  oif;
        logic        remote_rcv;
        logic        encap_req;
        logic        decap_req;
        logic        recirc;
        logic [13:0] len;
    } desc_t;

    // Rewrite instruction kinds
    typedef enum logic [1:0] {
        OP_FWD,
        OP_ENCAP,
        OP_DECAP
    } rw_op_t;

    // Word staged in the egress buffer
    typedef struct packed {
        logic [2:0]  port;
        rw_op_t      op;
        logic        to_recirc;
        desc_t       desc;
    } egr_t;

endpackage

/* src/switch_packet_path_queueing.sv */
// Packet path of one switching ASIC: lookup, queueing, replication, rewrite, recirculation
// ==========================================================
// Summary of operation
// - Arriving header goes to ingress lookup; packet body is held in the buffer.
// - Ingress lookup turns header fields into a control descriptor for the buffer.
// - Buffer attaches the descriptor to the stored packet before queueing.
// - Local egress: enqueue to stack scheduler, which passes on to egress scheduler.
// - Egress scheduler dequeues; buffer delivers packet to egress controller and rewrite.
// - Egress controller produces the final rewrite instruction for the packet.
// - Rewritten packet goes to the egress FIFO toward the front-panel port.
// - Remote egress: enqueue to ingress scheduler and wait for its dequeue.
// - On that dequeue, the packet with descriptor leaves on the stack.
// - Stack arrivals enter the buffer and queue via stack then egress scheduler.
// - Local multicast copies follow the packet's outgoing interface list.
// - Multicast is dequeued one copy at a time, each egressing separately.
// - After each copy leaves, the next is scheduled until the list is empty.
// - Remote multicast sends exactly one copy over the stack.
// - Wireless destination sets the encapsulation request in the descriptor unless the packet came from an access point.
// - Encapsulated packets leave the egress FIFO toward recirculation, not a port.
// - Recirculated packets get a new lookup, then final rewrite and port egress.
// - Access point traffic is decapsulated and converted before wired switching.
// - Wired traffic toward wireless clients is converted and encapsulated inside.
// - Recirculation feeds packets back into the ingress pipeline.
// - One shared 6MB buffer accounts for all packet storage.
`timescale 1ns/1ps
`default_nettype none
module switch_packet_path_queueing
    import pkt_path_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rst_b,
    input  wire logic [3:0] i_local_asic,
    input  wire hdr_t       i_net_hdr,
    input  wire logic       i_net_valid,
    output logic            o_net_ready,
    input  wire desc_t      i_stk_rx_desc,
    input  wire logic       i_stk_rx_valid,
    output logic            o_stk_rx_ready,
    output desc_t           o_stk_tx_desc,
    output logic            o_stk_tx_valid,
    input  wire logic       i_stk_tx_ready,
    output egr_t            o_port_word,
    output logic            o_port_valid,
    input  wire logic       i_port_ready,
    output logic            o_drop,
    output logic [22:0]     o_buf_used
);

    typedef enum logic [3:0] {
        S_IDLE,
        S_LOOKUP,
        S_ATTACH,
        S_IQS,
        S_SQS,
        S_EQS,
        S_EFC,
        S_REWRITE,
        S_RELEASE
    } state_t;

    state_t      state;
    state_t      next_state;
    hdr_t        hdr;
    desc_t       desc;
    desc_t       recirc_desc;
    logic        recirc_valid;
    logic        from_rc;
    logic        stack_in;
    logic        pick_stack;
    logic [7:0]  copy_mask;
    logic [7:0]  copy_pick;
    logic [8:0]  copy_seen;
    logic [2:0]  copy_port;
    egr_t        egr_word;
    egr_t        buf_head;
    logic        buf_in_ready;
    logic        buf_out_valid;

    // ==========================================================
    // Source selection and handshakes
    wire net_take  = i_net_valid && o_net_ready;
    wire stk_take  = i_stk_rx_valid && o_stk_rx_ready;
    wire rc_take   = (state == S_IDLE) && recirc_valid && !net_take && !stk_take;
    wire [22:0] room = BUF_BYTES_W - o_buf_used;
    wire too_big   = net_take && ({9'h000, i_net_hdr.len} > room);
    wire tx_done   = o_stk_tx_valid && i_stk_tx_ready;
    wire push      = (state == S_REWRITE) && buf_in_ready;
    wire more_copy = desc.mcast && |(copy_mask & ~copy_pick);

    // ==========================================================
    // Ingress lookup: first pass from header, second pass from recirculation
    desc_t first_desc;
    desc_t rc_pass_desc;
    desc_t lookup_desc;
    assign first_desc = '{dst_asic: hdr.dst_asic, dst_port: hdr.dst_port,
                          mcast: hdr.mcast, oif: hdr.oif, remote_rcv: hdr.remote_rcv,
                          encap_req: hdr.wireless_dst && !hdr.from_ap,
                          decap_req: hdr.from_ap,
                          recirc: 1'b0, len: hdr.len};
    // Outer header lookup only; rewrite requests were spent on the first pass
    assign rc_pass_desc = '{dst_asic: desc.dst_asic, dst_port: desc.dst_port,
                            mcast: desc.mcast, oif: desc.oif, remote_rcv: desc.remote_rcv,
                            encap_req: 1'b0, decap_req: 1'b0,
                            recirc: 1'b1, len: desc.len};
    assign lookup_desc = from_rc ? rc_pass_desc : first_desc;

    // Stack arrivals never bounce back out; rewrite passes stay local
    wire is_remote = desc.mcast ? desc.remote_rcv : (desc.dst_asic != i_local_asic);
    wire to_iqs    = !stack_in && !desc.encap_req && !desc.decap_req && is_remote;

    // ==========================================================
    // Lowest pending multicast copy, one bit per port
    assign copy_seen[0] = 1'b0;
    genvar gi;
    generate
        for (gi = 0; gi < PORTS; gi++) begin : g_copy
            assign copy_pick[gi]   = copy_mask[gi] && !copy_seen[gi];
            assign copy_seen[gi+1] = copy_seen[gi] || copy_mask[gi];
        end
    endgenerate

    // Encode the chosen copy into a port number
    always_comb begin
        copy_port = 3'h0;
        for (int k = 0; k < PORTS; k++) begin
            if (copy_pick[k]) begin
                copy_port = 3'(k);
            end
        end
    end

    // ==========================================================
    // Egress controller instruction
    wire rw_op_t efc_op = desc.encap_req ? OP_ENCAP : (desc.decap_req ? OP_DECAP : OP_FWD);
    wire [2:0]   efc_port = desc.mcast ? copy_port : desc.dst_port;

    // ==========================================================
    // Main sequencer
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (net_take && !too_big) begin
                    next_state = S_LOOKUP;
                end else if (stk_take) begin
                    next_state = S_ATTACH;
                end else if (rc_take) begin
                    next_state = S_LOOKUP;
                end
            end
            S_LOOKUP: next_state = S_ATTACH;
            S_ATTACH: next_state = to_iqs ? S_IQS : S_SQS;
            S_IQS: begin
                if (tx_done) begin
                    next_state = (desc.mcast && |copy_mask) ? S_SQS : S_RELEASE;
                end
            end
            S_SQS: next_state = S_EQS;
            S_EQS: begin
                if (desc.mcast && !(|copy_mask)) begin
                    next_state = S_RELEASE;
                end else if (buf_in_ready) begin
                    next_state = S_EFC;
                end
            end
            S_EFC: next_state = S_REWRITE;
            S_REWRITE: begin
                if (push) begin
                    next_state = more_copy ? S_EQS : S_RELEASE;
                end
            end
            S_RELEASE: next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    // State and source arbitration; ready only offered while idle
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state          <= S_IDLE;
            pick_stack     <= 1'b0;
            o_net_ready    <= 1'b0;
            o_stk_rx_ready <= 1'b0;
            o_drop         <= 1'b0;
        end else begin
            state          <= next_state;
            pick_stack     <= !pick_stack;
            o_net_ready    <= (next_state == S_IDLE) && pick_stack;
            o_stk_rx_ready <= (next_state == S_IDLE) && !pick_stack;
            o_drop         <= too_big;
        end
    end

    // Descriptor capture and attach
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hdr      <= '0;
            desc     <= '0;
            from_rc  <= 1'b0;
            stack_in <= 1'b0;
        end else if (state == S_IDLE) begin
            if (net_take) begin
                hdr      <= i_net_hdr;
                from_rc  <= 1'b0;
                stack_in <= 1'b0;
            end else if (stk_take) begin
                desc     <= i_stk_rx_desc;
                stack_in <= 1'b1;
            end else if (rc_take) begin
                desc     <= recirc_desc;
                from_rc  <= 1'b1;
                stack_in <= 1'b0;
            end
        end else if (state == S_LOOKUP) begin
            desc <= lookup_desc;
        end
    end

    // Shared buffer occupancy; multicast bytes held until the last copy
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_buf_used <= RST_USED;
        end else if (state == S_ATTACH) begin
            o_buf_used <= o_buf_used + {9'h000, desc.len};
        end else if (state == S_RELEASE) begin
            o_buf_used <= o_buf_used - {9'h000, desc.len};
        end
    end

    // Copy list of the active queue manager
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            copy_mask <= RST_MASK;
        end else if (state == S_ATTACH) begin
            copy_mask <= desc.mcast ? desc.oif : RST_MASK;
        end else if (push && desc.mcast) begin
            copy_mask <= copy_mask & ~copy_pick;
        end
    end

    // Stack transmit: one copy per packet, held until the scheduler dequeues it
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_stk_tx_valid <= 1'b0;
            o_stk_tx_desc  <= '0;
        end else if (state == S_ATTACH && to_iqs) begin
            o_stk_tx_valid <= 1'b1;
            o_stk_tx_desc  <= desc;
        end else if (tx_done) begin
            o_stk_tx_valid <= 1'b0;
        end
    end

    // Rewrite instruction latched from the egress controller
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            egr_word <= '0;
        end else if (state == S_EFC) begin
            egr_word <= '{port: efc_port, op: efc_op,
                          to_recirc: desc.encap_req || desc.decap_req, desc: desc};
        end
    end

    // ==========================================================
    // Egress FIFO; a stalled port or busy recirculation stalls the sequencer
    wire head_rc  = buf_head.to_recirc;
    wire port_rdy = !o_port_valid || i_port_ready;
    wire drain    = head_rc ? !recirc_valid : port_rdy;

    egress_skid_buffer #(
        .W($bits(egr_t))
    ) u_egress_fifo (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_data  (egr_word),
        .i_valid (state == S_REWRITE),
        .o_ready (buf_in_ready),
        .o_data  (buf_head),
        .i_ready (drain),
        .o_valid (buf_out_valid)
    );

    // Port stage and recirculation hold register
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_port_valid <= 1'b0;
            o_port_word  <= '0;
            recirc_valid <= 1'b0;
            recirc_desc  <= '0;
        end else begin
            if (buf_out_valid && !head_rc && port_rdy) begin
                o_port_valid <= 1'b1;
                o_port_word  <= buf_head;
            end else if (i_port_ready) begin
                o_port_valid <= 1'b0;
            end
            if (buf_out_valid && head_rc && !recirc_valid) begin
                recirc_valid <= 1'b1;
                recirc_desc  <= buf_head.desc;
            end else if (rc_take) begin
                recirc_valid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    chk_net_lookup: assert property (net_take && !too_big |=> state == S_LOOKUP)
        else $error("accepted header did not enter lookup");
    chk_encap_flag: assert property (state == S_LOOKUP && !from_rc && hdr.wireless_dst
        && !hdr.from_ap |=> desc.encap_req)
        else $error("wireless destination lost its encapsulation request");
    chk_stack_order: assert property (state == S_SQS |=> state == S_EQS)
        else $error("stack scheduler did not pass to egress scheduler");
    chk_iqs_hold: assert property (o_stk_tx_valid && !i_stk_tx_ready
        |=> o_stk_tx_valid && $stable(o_stk_tx_desc))
        else $error("stack copy dropped before dequeue");
    chk_one_copy: assert property (tx_done |=> !o_stk_tx_valid ##1 !o_stk_tx_valid)
        else $error("second stack copy of one packet");
    chk_copy_mask: assert property (push && desc.mcast
        |=> copy_mask == ($past(copy_mask) & ~$past(copy_pick)))
        else $error("served copy not removed from list");
    chk_release_last: assert property (state == S_RELEASE |-> !(desc.mcast && |copy_mask)
        && !o_stk_tx_valid)
        else $error("buffer released with copies pending");
    chk_no_rc_port: assert property (o_port_valid |-> !o_port_word.to_recirc)
        else $error("encapsulated packet sent to a port");
    chk_efc_op: assert property (state == S_EFC && desc.decap_req
        |=> egr_word.op == OP_DECAP && egr_word.to_recirc)
        else $error("decapsulation instruction missing");
    chk_used_back: assert property (state == S_RELEASE && !recirc_valid
        |=> o_buf_used == $past(o_buf_used) - {9'h000, $past(desc.len)})
        else $error("buffer accounting not returned");

endmodule
`default_nettype wire

/* tb/pkt_far_side.sv */
// Far side model: front-panel port sink and stack dequeue source
`timescale 1ns/1ps
`default_nettype none
module pkt_far_side (
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    input  wire logic i_slow,
    output logic      o_port_ready,
    output logic      o_stk_tx_ready
);
    logic [31:0] seed;

    // ==========================================================
    // Ready generation
    // Slow mode stalls at random so words must wait in the egress buffer
    initial begin
        seed = 32'h91864277;
        o_port_ready = 1'b0;
        o_stk_tx_ready = 1'b0;
    end
    always @(negedge i_clock) begin
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        o_port_ready <= i_rst_b && (!i_slow || seed[3]);
        o_stk_tx_ready <= i_rst_b && (!i_slow || seed[9]);
    end
endmodule
`default_nettype wire

/* tb/switch_packet_path_queueing_tb.sv */
// Self-checking bench of the switch packet path against a stalling far side
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module switch_packet_path_queueing_tb;
    import pkt_path_pkg::*;
    typedef struct packed {
        logic        last;
        logic [2:0]  port;
        rw_op_t      op;
        logic        to_recirc;
        logic        recirc;
        logic [13:0] len;
    } port_exp_t;
    typedef logic [18:0] stk_exp_t;

    logic        i_clock;
    logic        i_rst_b;
    logic [3:0]  i_local_asic;
    hdr_t        i_net_hdr;
    logic        i_net_valid;
    logic        o_net_ready;
    desc_t       i_stk_rx_desc;
    logic        i_stk_rx_valid;
    logic        o_stk_rx_ready;
    desc_t       o_stk_tx_desc;
    logic        o_stk_tx_valid;
    logic        i_stk_tx_ready;
    egr_t        o_port_word;
    logic        o_port_valid;
    logic        i_port_ready;
    logic        o_drop;
    logic [22:0] o_buf_used;
    logic        slow;
    logic [31:0] seed = 32'h91864277;
    int          fails = 0;
    int          comparisons = 0;
    port_exp_t   port_q[$];
    stk_exp_t    stk_q[$];
    port_exp_t   pe;
    stk_exp_t    se;
    wire logic [20:0] port_got = {o_port_word.port, o_port_word.op, o_port_word.to_recirc,
                                  o_port_word.desc.recirc, o_port_word.desc.len};
    wire logic [18:0] stk_got = {o_stk_tx_desc.dst_asic, o_stk_tx_desc.mcast,
                                 o_stk_tx_desc.len};

    switch_packet_path_queueing u_switch_packet_path_queueing (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_local_asic(i_local_asic),
        .i_net_hdr(i_net_hdr), .i_net_valid(i_net_valid), .o_net_ready(o_net_ready),
        .i_stk_rx_desc(i_stk_rx_desc), .i_stk_rx_valid(i_stk_rx_valid),
        .o_stk_rx_ready(o_stk_rx_ready), .o_stk_tx_desc(o_stk_tx_desc),
        .o_stk_tx_valid(o_stk_tx_valid), .i_stk_tx_ready(i_stk_tx_ready),
        .o_port_word(o_port_word), .o_port_valid(o_port_valid),
        .i_port_ready(i_port_ready), .o_drop(o_drop), .o_buf_used(o_buf_used));

    pkt_far_side u_pkt_far_side (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_slow(slow),
        .o_port_ready(i_port_ready), .o_stk_tx_ready(i_stk_tx_ready));

    // ==========================================================
    // Clock
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    // ==========================================================
    // Helpers
    // Xorshift keeps the run repeatable
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected port copies and stack sends of one packet
    function automatic void expect_pkt(input logic [3:0] asic, input logic [2:0] dport,
            input logic mc, input logic [7:0] oif, input logic rem, input logic rc,
            input logic [13:0] len);
        int last;
        last = -1;
        for (int p = 0; p < PORTS; p++)
            if (oif[p]) last = p;
        if (!mc && asic != i_local_asic) stk_q.push_back({asic, 1'b0, len});
        else if (!mc) port_q.push_back({1'b1, dport, OP_FWD, 1'b0, rc, len});
        else begin
            if (rem) stk_q.push_back({asic, 1'b1, len});
            for (int p = 0; p < PORTS; p++)
                if (oif[p]) port_q.push_back({p == last, 3'(p), OP_FWD, 2'b00, len});
        end
    endfunction

    task automatic results();
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic timeout();
        fails++;
        results();
    endtask

    // Offer one header or stack descriptor; released lines carry junk
    task automatic offer(input logic stk, input hdr_t h, input desc_t d);
        int n;
        n = 0;
        i_net_hdr = h;
        i_stk_rx_desc = d;
        i_net_valid = !stk;
        i_stk_rx_valid = stk;
        while ((stk ? o_stk_rx_ready : o_net_ready) !== 1'b1 && n < 200) begin
            @(negedge i_clock);
            n++;
        end
        if (n >= 200) timeout();
        @(negedge i_clock);
        i_net_valid = 1'b0;
        i_stk_rx_valid = 1'b0;
        i_net_hdr = ~h;
        i_stk_rx_desc = ~d;
    endtask

    // Wait until every copy and stack send is out and the buffer is empty
    task automatic drain();
        int n;
        n = 0;
        while ((port_q.size() + stk_q.size() != 0 || o_buf_used !== RST_USED) && n < 3000) begin
            @(negedge i_clock);
            n++;
        end
        if (n >= 3000) timeout();
        `CHECK(o_buf_used, RST_USED)
    endtask

    // One packet of a given kind; field values come from r
    task automatic pkt(input logic [2:0] kind, input logic [31:0] r);
        hdr_t  h;
        desc_t d;
        h = '0;
        d = '0;
        h.dst_asic = (kind == 3'h1) ? (i_local_asic ^ (r[11:8] | 4'h1)) : i_local_asic;
        h.dst_port = r[7:5];
        h.mcast = kind == 3'h2 || kind == 3'h3 || kind == 3'h7;
        h.oif = r[19:12] | 8'h01;
        h.remote_rcv = kind == 3'h3;
        h.wireless_dst = kind == 3'h4;
        h.from_ap = kind == 3'h5;
        h.len = r[31:18];
        d = {h.dst_asic, h.dst_port, h.mcast, h.oif, 4'h0, h.len};
        expect_pkt(h.dst_asic, h.dst_port, h.mcast, h.oif, h.remote_rcv,
                   h.wireless_dst | h.from_ap, h.len);
        offer(kind[2] & kind[1], h, d);
        drain();
    endtask

    // ==========================================================
    // Output monitor: every taken word must match the next expectation
    always @(posedge i_clock) begin
        if (i_rst_b && o_port_valid && i_port_ready) begin
            pe = (port_q.size() != 0) ? port_q.pop_front() : '1;
            `CHECK(port_got, pe[20:0])
            // A stalled port may hold an early copy past the release, so only a free port
            // guarantees that the last copy is still waiting for its dequeue here
            if (!pe.last && !slow) `CHECK(o_buf_used, 23'(pe.len))
        end
        // Pop once, so a mismatch report cannot consume a second expectation
        if (i_rst_b && o_stk_tx_valid && i_stk_tx_ready) begin
            se = (stk_q.size() != 0) ? stk_q.pop_front() : 19'h7ffff;
            `CHECK(stk_got, se)
        end
        if (o_drop !== 1'b0) `CHECK(o_drop, 1'b0)
    end

    // ==========================================================
    // Main sequence: reset, corner table, then random traffic
    initial begin
        i_rst_b = 1'b0;
        i_local_asic = 4'h3;
        i_net_hdr = '0;
        i_net_valid = 1'b0;
        i_stk_rx_desc = '0;
        i_stk_rx_valid = 1'b0;
        slow = 1'b0;
        repeat (10) @(negedge i_clock);
        `CHECK({o_port_valid, o_stk_tx_valid, o_net_ready, o_buf_used}, 26'h0)
        i_rst_b = 1'b1;
        // Every kind once fast then once stalling; even kinds at the largest length, odd kinds at the smallest
        for (int k = 0; k < 16; k++) begin
            slow = k[3];
            pkt(3'(k), k[0] ? 32'h00041000 : 32'hfffff0e0);
        end
        for (int k = 0; k < 60; k++) begin
            slow = rnd() > 32'h80000000;
            pkt(3'(rnd()), rnd());
        end
        results();
    end
endmodule
`default_nettype wire
